// ---- bench/tmx_hdmi_tx_monitor.sv ----
// Purpose: port checker for tmx_hdmi_tx
// Assumes: zero wait state apb, fast clock five times clk_in
// Notes:   bound to every tmx_hdmi_tx
`timescale 1ns/10ps
module tmx_hdmi_tx_monitor
    import tmx_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic        fast_bit_clock_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        tmds_clk_out
);
    logic mapped;
    assign mapped = paddr_in == CTRL_OFFSET || paddr_in == STATUS_OFFSET;
    sequence s_acc;
        psel_in && penable_in;
    endsequence
    sequence s_rd;
        psel_in && !penable_in && !pwrite_in ##1 s_acc;
    endsequence
    property p_ready;
        @(posedge clk_in) disable iff (sys_rst_in) s_acc |-> pready_out;
    endproperty
    property p_err;
        @(posedge clk_in) disable iff (sys_rst_in) s_acc |-> pslverr_out == !mapped;
    endproperty
    property p_rd_unmapped;
        @(posedge clk_in) disable iff (sys_rst_in) s_rd ##0 !mapped |-> prdata_out == 32'h0;
    endproperty
    property p_rd_ctrl;
        @(posedge clk_in) disable iff (sys_rst_in)
            s_rd ##0 paddr_in == CTRL_OFFSET |-> prdata_out[31:1] == 31'h0;
    endproperty
    property p_rd_status;
        @(posedge clk_in) disable iff (sys_rst_in)
            s_rd ##0 paddr_in == STATUS_OFFSET |-> prdata_out[31:4] == 28'h0;
    endproperty
    property p_ctrl_wr;
        @(posedge clk_in) disable iff (sys_rst_in)
            s_acc ##0 pwrite_in && paddr_in == CTRL_OFFSET ##2 s_rd ##0 paddr_in == CTRL_OFFSET
            |-> prdata_out[CTRL_HDMI_BIT] == $past(pwdata_in[CTRL_HDMI_BIT], 3);
    endproperty
    property p_fwd_clk;
        @(posedge fast_bit_clock_in) disable iff (sys_rst_in)
            $rose(tmds_clk_out) |-> ##[2:3] $fell(tmds_clk_out) ##[2:3] $rose(tmds_clk_out);
    endproperty
    property p_fwd_rst;
        @(posedge clk_in) sys_rst_in ##1 sys_rst_in |-> !tmds_clk_out;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    a_err: assert property (p_err) else $error("pslverr wrong for address");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl spare bits set");
    a_rd_status: assert property (p_rd_status) else $error("status spare bits set");
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl readback differs");
    a_fwd_clk: assert property (p_fwd_clk) else $error("forwarded clock period wrong");
    a_fwd_rst: assert property (p_fwd_rst) else $error("forwarded clock high in reset");
endmodule : tmx_hdmi_tx_monitor

bind tmx_hdmi_tx tmx_hdmi_tx_monitor i_monitor (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .fast_bit_clock_in(fast_bit_clock_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .tmds_clk_out(tmds_clk_out)
);

// ---- bench/tmx_hdmi_tx_tb.sv ----
// Purpose: self-checking bench for tmx_hdmi_tx
// Assumes: fast clock toggled on its own beside clk_in, exact five to one
// Notes:   stream aligned on first preamble, video symbols decoded
`timescale 1ns/10ps
module tmx_hdmi_tx_tb
    import tmx_pkg::*;
;
    typedef struct packed {
        logic        ve;
        logic        ae;
        logic        hs;
        logic        vs;
        logic [23:0] rgb;
        logic [11:0] aux;
    } tmx_px_t;
    typedef struct packed {
        logic        wr;
        logic [11:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        err;
    } tmx_op_t;
    logic        clk_in = 1'b0;
    logic        fclk = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        psel_in, penable_in, pwrite_in, hsync_in, vsync_in, pready_out, pslverr_out;
    logic        video_active_enable_in, aux_island_enable_in, tmds_clk_out, er;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [7:0]  red_in, green_in, blue_in;
    logic [3:0]  red_aux_in, green_aux_in, blue_aux_nibble_in;
    logic [2:0]  tmds_data_out;
    tmx_px_t     cur;
    tmx_px_t     hist [$];
    int          err_count = 0;
    int          compares = 0;
    tmx_op_t     ops [9] = '{
        '{0, CTRL_OFFSET, 32'h0, CTRL_RESET, 0}, '{0, STATUS_OFFSET, 32'h0, 32'h0, 0},
        '{1, STATUS_OFFSET, 32'hf, 32'h0, 0}, '{0, STATUS_OFFSET, 32'h0, 32'h0, 0},
        '{0, 12'h008, 32'h0, 32'h0, 1}, '{1, 12'hffc, 32'h1, 32'h0, 1},
        '{1, CTRL_OFFSET, 32'h0, 32'h0, 0}, '{0, CTRL_OFFSET, 32'h0, 32'h0, 0},
        '{0, CTRL_OFFSET, 32'h0, CTRL_RESET, 0}};

    always #2.5 clk_in = ~clk_in;
    always #0.5 fclk = ~fclk;
    assign {video_active_enable_in, aux_island_enable_in, hsync_in, vsync_in, red_in, green_in,
            blue_in, red_aux_in, green_aux_in, blue_aux_nibble_in} = cur;

    tmx_hdmi_tx i_dut (
        .clk_in, .sys_rst_in, .fast_bit_clock_in(fclk), .fast_bit_clock_inverted_in(~fclk),
        .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .red_in, .green_in, .blue_in, .hsync_in, .vsync_in,
        .video_active_enable_in, .aux_island_enable_in, .red_aux_in, .green_aux_in,
        .blue_aux_nibble_in, .tmds_data_out, .tmds_clk_out
    );
    tmx_tmds_sink i_sink (.fast_bit_clock_in(fclk), .tmds_data_in(tmds_data_out));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic reset_dut();
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
    endtask : reset_dut

    task automatic drive(input int n, input logic ve, input logic ae);
        tmx_px_t p;
        repeat (n) begin
            p = tmx_px_t'({ve, ae, 38'({$urandom, $urandom})});
            @(posedge clk_in);
            cur <= p;
            hist.push_back(p);
        end
    endtask : drive

    task automatic apb(input tmx_op_t op);
        int n;
        @(posedge clk_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, op.wr, op.a, op.wd};
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            end_of_test();
        end
        rd = prdata_out;
        er = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask : apb

    function automatic logic [7:0] dec(input logic [9:0] s);
        logic [7:0] d;
        logic [7:0] q;
        d = s[9] ? ~s[7:0] : s[7:0];
        q[0] = d[0];
        for (int i = 1; i < 8; i++) q[i] = s[8] ? d[i] ^ d[i-1] : ~(d[i] ^ d[i-1]);
        return q;
    endfunction : dec

    function automatic logic [29:0] expect_sym(input int k);
        tmx_px_t c, t8, d;
        logic [3:0] pre;
        c = hist[k];
        t8 = hist[k-8];
        d = hist[k-10];
        pre = c.ve ? PRE_VIDEO : c.ae ? PRE_ISLAND : PRE_NONE;
        if (d.ve) return {6'h0, d.rgb};
        if (d.ae)
            return {TERC4[d.aux[11:8]], TERC4[d.aux[7:4]], TERC4[{d.aux[3:2], d.vs, d.hs}]};
        if (t8.ve) return {VID_GUARD[RED_CH], VID_GUARD[GREEN_CH], VID_GUARD[BLUE_CH]};
        if (t8.ae || hist[k-11].ae || hist[k-12].ae)
            return {ISL_GUARD, ISL_GUARD, TERC4[{ISL_GUARD_HI, d.vs, d.hs}]};
        return {CTRL_TOKEN[pre[3:2]], CTRL_TOKEN[pre[1:0]], CTRL_TOKEN[{d.vs, d.hs}]};
    endfunction : expect_sym

    task automatic check_stream();
        logic [29:0] w;
        int i;
        i = 11;
        do begin
            i++;
            w = expect_sym(i);
        end while (w[19:10] == CTRL_TOKEN[0] && i < hist.size() - 11);
        while (i_sink.words.size() > 0 && i_sink.words[0][19:10] === CTRL_TOKEN[0])
            void'(i_sink.words.pop_front());
        for (int k = i; k < hist.size() - 10; k++) begin
            if (i_sink.words.size() == 0) begin
                check("word count", 32'h1, 32'h0);
                return;
            end
            w = i_sink.words.pop_front();
            if (hist[k-10].ve) w = {6'h0, dec(w[29:20]), dec(w[19:10]), dec(w[9:0])};
            check("symbol", 32'(expect_sym(k)), 32'(w));
        end
    endtask : check_stream

    initial begin
        cur = '0;
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        void'($urandom(32'h7644));
        reset_dut();
        drive(30, 0, 0);
        i_sink.words.delete();
        drive(12, 0, 0);
        drive(16, 1, 0);
        drive(10, 0, 0);
        drive(6, 0, 1);
        drive(12, 0, 0);
        drive(5, 1, 0);
        drive(30, 0, 0);
        // let the last symbols clear the delay line, fifo and serializer
        repeat (20) @(posedge clk_in);
        check_stream();
        for (int j = 0; j < 9; j++) begin
            if (j == 8) reset_dut();
            apb(ops[j]);
            if (!ops[j].wr) check("prdata", ops[j].exp, rd);
            check("pslverr", 32'(ops[j].err), 32'(er));
        end
        end_of_test();
    end

    initial begin
        #300000;
        err_count++;
        end_of_test();
    end
endmodule : tmx_hdmi_tx_tb

// ---- bench/tmx_tmds_sink.sv ----
// Purpose: behavioural tmds sink, rebuilds 30-bit symbol words
// Assumes: one bit per fast clock half period
// Notes:   word phase found on the first idle green token
`timescale 1ns/10ps
module tmx_tmds_sink
    import tmx_pkg::*;
(
    input wire logic       fast_bit_clock_in,
    input wire logic [2:0] tmds_data_in
);
    logic [29:0] words [$];
    logic [9:0]  win [NUM_CH];
    int          nbits = 0;
    int          phase = -1;

    // sample away from the ddr mux switching point
    always @(fast_bit_clock_in) begin
        #0.25;
        for (int c = 0; c < NUM_CH; c++) win[c] = {tmds_data_in[c], win[c][9:1]};
        nbits++;
        if (phase < 0 && win[GREEN_CH] === CTRL_TOKEN[0]) phase = nbits % SYM_W;
        else if (phase >= 0 && nbits % SYM_W == phase) words.push_back({win[2], win[1], win[0]});
    end
endmodule : tmx_tmds_sink

// ---- design/tmx_hdmi_tx.sv ----
// Purpose: hdmi/dvi tmds transmitter: delay line, period encoder, apb registers
// Assumes: video timing source runs on clk_in; fast clocks come from a clock synth
// Notes:   serial pins are single-ended halves of the differential pairs
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
module tmx_hdmi_tx
    import tmx_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        fast_bit_clock_in,
    input  wire logic        fast_bit_clock_inverted_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [7:0]  red_in,
    input  wire logic [7:0]  green_in,
    input  wire logic [7:0]  blue_in,
    input  wire logic        hsync_in,
    input  wire logic        vsync_in,
    input  wire logic        video_active_enable_in,
    input  wire logic        aux_island_enable_in,
    input  wire logic [3:0]  red_aux_in,
    input  wire logic [3:0]  green_aux_in,
    input  wire logic [3:0]  blue_aux_nibble_in,
    output logic      [2:0]  tmds_data_out,
    output logic             tmds_clk_out
);

    logic [DL_W-1:0]         dl_tap [DELAY_TAPS+1];
    logic [1:0]              aux_tail;
    logic                    hdmi_mode;
    logic                    video_enable_delayed;
    logic                    aux_enable_delayed;
    logic                    vs_d;
    logic                    hs_d;
    logic [3:0]              preamble_ctrl_bus;
    tmx_period_t             period;
    logic [NUM_CH*SYM_W-1:0] sym_word;
    logic                    reg_hit;
    logic [31:0]             next_rdata;

    function automatic logic [15:0] tmds_encode(
        input logic [7:0]        d,
        input logic signed [5:0] cnt
    );
        logic [8:0]        qm;
        logic [3:0]        n1d;
        logic [3:0]        n1q;
        logic              use_xnor;
        logic signed [5:0] diff;
        logic signed [5:0] nc;
        logic [9:0]        q;
        n1d = '0;
        n1q = '0;
        for (int i = 0; i < PIX_W; i++) begin
            n1d = n1d + {3'h0, d[i]};
        end
        use_xnor = (n1d > 4'h4) || ((n1d == 4'h4) && !d[0]);
        qm[0] = d[0];
        for (int i = 1; i < PIX_W; i++) begin
            qm[i] = use_xnor ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
        end
        qm[8] = ~use_xnor;
        for (int i = 0; i < PIX_W; i++) begin
            n1q = n1q + {3'h0, qm[i]};
        end
        diff = $signed({1'b0, n1q, 1'b0}) - DISP_HALF;
        if ((cnt == DISP_ZERO) || (diff == DISP_ZERO)) begin
            q  = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
            nc = qm[8] ? (cnt + diff) : (cnt - diff);
        end else if (((cnt > DISP_ZERO) && (diff > DISP_ZERO)) ||
                     ((cnt < DISP_ZERO) && (diff < DISP_ZERO))) begin
            q  = {1'b1, qm[8], ~qm[7:0]};
            nc = cnt + (qm[8] ? DISP_TWO : DISP_ZERO) - diff;
        end else begin
            q  = {1'b0, qm[8], qm[7:0]};
            nc = cnt - (qm[8] ? DISP_ZERO : DISP_TWO) + diff;
        end
        return {nc, q};
    endfunction : tmds_encode

    // shift_delay_line: tap 0 is the live input word
    assign dl_tap[0] = {video_active_enable_in, aux_island_enable_in, vsync_in, hsync_in,
                        red_aux_in, green_aux_in, blue_aux_nibble_in,
                        red_in, green_in, blue_in};

    for (genvar t = 1; t <= DELAY_TAPS; t++) begin : g_tap
        always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
                dl_tap[t] <= '0;
            end else begin
                dl_tap[t] <= dl_tap[t-1];
            end
        end
    end

    // two more taps of the island enable mark the trailing guardband
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            aux_tail <= '0;
        end else begin
            aux_tail <= {aux_tail[0], aux_enable_delayed};
        end
    end

    assign video_enable_delayed = dl_tap[DELAY_TAPS][POS_VDE];
    assign aux_enable_delayed   = dl_tap[DELAY_TAPS][POS_ADE];
    assign vs_d                 = dl_tap[DELAY_TAPS][POS_VSYNC];
    assign hs_d                 = dl_tap[DELAY_TAPS][POS_HSYNC];

    // period lookup: the live enables look ten pixels ahead of the encoder
    always_comb begin
        period            = TMX_CTRL;
        preamble_ctrl_bus = PRE_NONE;
        if (video_enable_delayed) begin
            period = TMX_VIDEO;
        end else if (!hdmi_mode) begin
            period = TMX_CTRL;
        end else if (aux_enable_delayed) begin
            period = TMX_ISLAND;
        end else if (dl_tap[GUARD_TAP][POS_VDE]) begin
            period = TMX_GUARD;
        end else if (dl_tap[GUARD_TAP][POS_ADE]) begin
            period = TMX_ISL_LEAD;
        end else if (|aux_tail) begin
            period = TMX_ISL_TAIL;
        end else if (video_active_enable_in) begin
            period            = TMX_PRE;
            preamble_ctrl_bus = PRE_VIDEO;
        end else if (aux_island_enable_in) begin
            period            = TMX_PRE;
            preamble_ctrl_bus = PRE_ISLAND;
        end
    end

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        logic [PIX_W-1:0]        pix;
        logic [AUX_W-1:0]        aux;
        logic [1:0]              ctl;
        logic [AUX_W-1:0]        isl_nib;
        logic [AUX_W-1:0]        guard_nib;
        logic [15:0]             enc;
        logic signed [5:0]       disparity;
        logic [SYM_W-1:0]        next_sym;
        logic [SYM_W-1:0]        sym;

        assign pix = dl_tap[DELAY_TAPS][ch*PIX_W +: PIX_W];
        assign aux = dl_tap[DELAY_TAPS][AUX_LSB + ch*AUX_W +: AUX_W];
        assign enc = tmds_encode(pix, disparity);

        if (ch == BLUE_CH) begin : g_blue
            assign ctl       = {vs_d, hs_d};
            assign isl_nib   = {aux[3:2], vs_d, hs_d};
            assign guard_nib = {ISL_GUARD_HI, vs_d, hs_d};
        end else begin : g_color
            assign ctl       = (ch == GREEN_CH) ? preamble_ctrl_bus[1:0]
                                                : preamble_ctrl_bus[3:2];
            assign isl_nib   = aux;
            assign guard_nib = '0;
        end

        always_comb begin
            case (period)
                TMX_VIDEO:    next_sym = enc[SYM_W-1:0];
                TMX_GUARD:    next_sym = VID_GUARD[ch];
                TMX_ISLAND:   next_sym = TERC4[isl_nib];
                TMX_ISL_LEAD,
                TMX_ISL_TAIL: next_sym = (ch == BLUE_CH) ? TERC4[guard_nib]
                                                         : ISL_GUARD;
                default:      next_sym = CTRL_TOKEN[ctl];
            endcase
        end

        // running disparity only lives inside active video
        always_ff @(posedge clk_in) begin
            if (sys_rst_in || (period != TMX_VIDEO)) begin
                disparity <= DISP_ZERO;
            end else begin
                disparity <= $signed(enc[15:10]);
            end
        end

        always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
                sym <= CTRL_TOKEN[0];
            end else begin
                sym <= next_sym;
            end
        end

        assign sym_word[ch*SYM_W +: SYM_W] = sym;
    end

    tmx_serializer u_ser (
        .clk_in                     (clk_in),
        .sys_rst_in                 (sys_rst_in),
        .fast_bit_clock_in          (fast_bit_clock_in),
        .fast_bit_clock_inverted_in (fast_bit_clock_inverted_in),
        .sym_in                     (sym_word),
        .tmds_data_out              (tmds_data_out),
        .tmds_clk_out               (tmds_clk_out)
    );

    // apb slave: zero wait states, read data captured in the setup cycle
    assign pready_out = 1'b1;

    always_comb begin
        reg_hit    = 1'b0;
        next_rdata = '0;
        if (paddr_in == CTRL_OFFSET) begin
            reg_hit                   = 1'b1;
            next_rdata[CTRL_HDMI_BIT] = hdmi_mode;
        end else if (paddr_in == STATUS_OFFSET) begin
            reg_hit                          = 1'b1;
            next_rdata[STAT_VIDEO_BIT]    = video_enable_delayed;
            next_rdata[STAT_ISLAND_BIT]   = (period == TMX_ISLAND);
            next_rdata[STAT_PREAMBLE_BIT] = (period == TMX_PRE);
            next_rdata[STAT_GUARD_BIT]    = (period == TMX_GUARD) ||
                                            (period == TMX_ISL_LEAD) ||
                                            (period == TMX_ISL_TAIL);
        end
    end

    assign pslverr_out = psel_in && penable_in && !reg_hit;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prdata_out <= '0;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            prdata_out <= next_rdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            hdmi_mode <= CTRL_RESET[CTRL_HDMI_BIT];
        end else if (psel_in && penable_in && pwrite_in && (paddr_in == CTRL_OFFSET)) begin
            hdmi_mode <= pwdata_in[CTRL_HDMI_BIT];
        end
    end

endmodule : tmx_hdmi_tx

// ---- design/tmx_pkg.sv ----
// Purpose: shared constants for the three-channel tmds transmitter
// Assumes: pixel clock is clk_in; two fivefold clocks 180 degrees apart
// Notes:   register map, symbol tables, delay line layout, fifo geometry
package tmx_pkg;

    // register map (apb byte addresses)
    localparam logic [11:0] CTRL_OFFSET       = 12'h000;
    localparam logic [11:0] STATUS_OFFSET     = 12'h004;
    localparam int          CTRL_HDMI_BIT     = 0;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0001;
    localparam int          STAT_VIDEO_BIT    = 0;
    localparam int          STAT_ISLAND_BIT   = 1;
    localparam int          STAT_PREAMBLE_BIT = 2;
    localparam int          STAT_GUARD_BIT    = 3;

    // channels
    localparam int NUM_CH   = 3;
    localparam int BLUE_CH  = 0;
    localparam int GREEN_CH = 1;
    localparam int RED_CH   = 2;
    localparam int SYM_W    = 10;

    // delay line: 40 bits, 10 taps = 8 preamble slots + 2 leading guardband slots
    localparam int DL_W          = 40;
    localparam int DELAY_TAPS    = 10;
    localparam int PREAMBLE_LEN  = 8;
    localparam int GUARD_TAP     = DELAY_TAPS - 2;
    localparam int POS_VDE       = 39;
    localparam int POS_ADE       = 38;
    localparam int POS_VSYNC     = 37;
    localparam int POS_HSYNC     = 36;
    localparam int AUX_LSB       = 24;
    localparam int AUX_W         = 4;
    localparam int PIX_W         = 8;

    // preamble control bus codes {red c1,c0, green c1,c0}
    localparam logic [3:0] PRE_NONE   = 4'h0;
    localparam logic [3:0] PRE_VIDEO  = 4'h1;
    localparam logic [3:0] PRE_ISLAND = 4'h5;

    localparam logic [9:0] CTRL_TOKEN [4] = '{
        10'h354, 10'h0ab, 10'h154, 10'h2ab};
    localparam logic [9:0] VID_GUARD [NUM_CH] = '{10'h2cc, 10'h133, 10'h2cc};
    localparam logic [9:0] ISL_GUARD = 10'h133;
    localparam logic [1:0] ISL_GUARD_HI = 2'h3;

    localparam logic [9:0] TERC4 [16] = '{
        10'h29c, 10'h263, 10'h2e4, 10'h2e2, 10'h171, 10'h11e, 10'h18e, 10'h13c,
        10'h2cc, 10'h139, 10'h19c, 10'h2c6, 10'h28e, 10'h271, 10'h163, 10'h2c3};

    // disparity arithmetic
    localparam logic signed [5:0] DISP_ZERO = 6'sh00;
    localparam logic signed [5:0] DISP_HALF = 6'sh08;
    localparam logic signed [5:0] DISP_TWO  = 6'sh02;

    // serializer
    localparam int          FIFO_DEPTH = 8;
    localparam int          PTR_W      = 3;
    localparam logic [2:0]  WR_START   = 3'h4;
    localparam int          STAGES     = 5;
    localparam logic [2:0]  LAST_STAGE = 3'h4;

    typedef enum logic [2:0] {
        TMX_CTRL     = 3'b000,
        TMX_PRE      = 3'b001,
        TMX_GUARD    = 3'b011,
        TMX_VIDEO    = 3'b010,
        TMX_ISL_LEAD = 3'b110,
        TMX_ISLAND   = 3'b111,
        TMX_ISL_TAIL = 3'b101
    } tmx_period_t;

endpackage : tmx_pkg

// ---- design/tmx_serializer.sv ----
// Purpose: 30:3 ddr serializer with free-running crossing fifo and forwarded clock
// Assumes: fast clocks run at five times clk_in, inverted copy is 180 degrees off
// Notes:   each symbol leaves lsb first, even bits on rising, odd on falling half
`timescale 1ns/10ps
module tmx_serializer
    import tmx_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    input  wire logic                    fast_bit_clock_in,
    input  wire logic                    fast_bit_clock_inverted_in,
    input  wire logic [NUM_CH*SYM_W-1:0] sym_in,
    output logic      [NUM_CH-1:0]       tmds_data_out,
    output logic                         tmds_clk_out
);

    logic [NUM_CH*SYM_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0]        wr_ptr;
    logic [PTR_W-1:0]        fifo_read_pointer;
    logic [1:0]              rst_p_sync;
    logic [1:0]              rst_n_sync;
    logic [2:0]              stage_p;
    logic [2:0]              stage_n;
    logic [NUM_CH*SYM_W-1:0] latched_symbol_word;
    logic [NUM_CH*SYM_W-1:0] latched_symbol_word_n;
    logic [NUM_CH-1:0]       rise_q;
    logic [NUM_CH-1:0]       fall_q;
    logic                    fwd_rise;
    logic                    fwd_fall;
    logic                    syncp_last;
    logic                    syncn_last;

    // pixel side writes every cycle, no flow control
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_ptr <= WR_START;
        end else begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        fifo_mem[wr_ptr] <= sym_in;
    end

    // reset release into each fast domain
    always_ff @(posedge fast_bit_clock_in) begin
        rst_p_sync <= {rst_p_sync[0], sys_rst_in};
    end

    always_ff @(posedge fast_bit_clock_inverted_in) begin
        rst_n_sync <= {rst_n_sync[0], sys_rst_in};
    end

    assign syncp_last = (stage_p == LAST_STAGE);
    assign syncn_last = (stage_n == LAST_STAGE);

    // stage sequencer, one read per five fast cycles matches the write rate
    always_ff @(posedge fast_bit_clock_in) begin
        if (rst_p_sync[1]) begin
            stage_p <= '0;
        end else if (syncp_last) begin
            stage_p <= '0;
        end else begin
            stage_p <= stage_p + 1'b1;
        end
    end

    always_ff @(posedge fast_bit_clock_in) begin
        if (rst_p_sync[1]) begin
            fifo_read_pointer   <= '0;
            latched_symbol_word <= '0;
        end else if (syncp_last) begin
            fifo_read_pointer   <= fifo_read_pointer + 1'b1;
            latched_symbol_word <= fifo_mem[fifo_read_pointer];
        end
    end

    // even bits, lsb first
    always_ff @(posedge fast_bit_clock_in) begin
        if (rst_p_sync[1]) begin
            rise_q <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                rise_q[ch] <= latched_symbol_word[ch*SYM_W + 2*stage_p];
            end
        end
    end

    // inverted domain follows the rising domain half a fast cycle later;
    // both clocks come from one source so this half-cycle path is timed
    always_ff @(posedge fast_bit_clock_inverted_in) begin
        if (rst_n_sync[1]) begin
            stage_n               <= '0;
            latched_symbol_word_n <= '0;
        end else begin
            stage_n <= stage_p;
            if (syncn_last) begin
                latched_symbol_word_n <= latched_symbol_word;
            end
        end
    end

    always_ff @(posedge fast_bit_clock_inverted_in) begin
        if (rst_n_sync[1]) begin
            fall_q <= '0;
        end else begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                fall_q[ch] <= latched_symbol_word_n[ch*SYM_W + 2*stage_n + 1];
            end
        end
    end

    // ddr_output_register model: rising half carries even bit, falling half odd
    assign tmds_data_out = fast_bit_clock_in ? rise_q : fall_q;

    // forwarded pixel clock: ddr register on clk_in and its inverse, data 1 and 0
    always_ff @(posedge clk_in) begin
        fwd_rise <= ~sys_rst_in;
    end

    always_ff @(negedge clk_in) begin
        fwd_fall <= 1'b0;
    end

    assign tmds_clk_out = clk_in ? fwd_rise : fwd_fall;

endmodule : tmx_serializer
